// File: tdx_top.sv
// Function
// (RULE1) mask bit reads one while its interrupt source is enabled
// (RULE2) result_ready sets at end of a run; zero means output invalid
// (RULE3) start command and soft reset clear result_ready
// (RULE4) last_output_mode zero: output word read clears result_ready
// (RULE5) last_output_mode one: input word write clears result_ready
// (RULE6) in DMA method result_ready moves on its own
// (RULE7) recv_count_done: receive counter reached zero since last write
// (RULE8) xmit_count_done: transmit counter reached zero since last write
// (RULE9) recv_buffers_full: both receive counters zero
// (RULE10) xmit_buffers_empty: both transmit counters zero
// (RULE11) bad_access_flag sets on unspecified access, soft reset clears
// (RULE12) bad_access_flag survives reads and other writes
// (RULE13) bad_access_kind codes the four unspecified access types
// (RULE14) bad_access_kind keeps the latest type until soft reset
// (RULE15) first key is two words, first then last
// (RULE16) key words are write-only
// (RULE17) second key used only in triple mode
// (RULE18) third key ignored in single and two-key triple
// (RULE19) input block from two write-only words, first then last
// (RULE20) result as two read-only words, first then last
// (RULE21) chaining vector from two write-only words
// (RULE22) software leaves chaining vector alone in code book mode
// (RULE23) result goes to output words or to the DMA receive side
// (RULE24) key_count_select one runs the two-key triple algorithm
// (RULE25) interrupt output when a masked-in status flag is set
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "tdx_map.svh"
module tdx_top
  import tdx_pkg::*;
#(
  parameter int AW  = 12,
  parameter int CW  = 16,
  parameter int LAT = 16
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // axi4-lite write
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic      [1:0]    s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // axi4-lite read
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic      [31:0]   s_axi_rdata,
  output logic      [1:0]    s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // dma transmit side, words into the engine
  output logic               dma_tx_req,
  input  wire logic          dma_tx_valid,
  input  wire logic [31:0]   dma_tx_data,
  // dma receive side, words out of the engine
  output logic               dma_rx_req,
  output logic      [31:0]   dma_rx_data,
  input  wire logic          dma_rx_ack,
  // interrupt
  output logic               irq
);
  // ****************************************
  // state
  // ****************************************
  tdx_state_t  st_reg;
  tdx_mode_t   mode_reg;
  tdx_keys_t   keys_reg;
  logic [63:0] in_reg;
  logic [63:0] iv_reg;
  logic [63:0] out_reg;
  logic [1:0]  in_seen_reg;
  logic        dma_idx_reg;
  logic [8:0]  mask_reg;
  logic        ready_reg;
  logic        bad_reg;
  logic [1:0]  kind_reg;
  logic        aw_full;
  logic        w_full;
  logic [AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [CW-1:0] rcnt;
  logic [CW-1:0] rnext;
  logic [CW-1:0] tcnt;
  logic [CW-1:0] tnext;
  logic        rdone;
  logic        tdone;
  logic        rfull;
  logic        tempty;
  logic        core_busy;
  logic        core_done;
  logic [63:0] core_res;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic is_wo(input logic [AW-1:0] a);
    // (RULE16) keys, input and vector never read back
    is_wo = a == AW'(`TDX_OFF_CTRL) || a == AW'(`TDX_OFF_IEN) ||
            a == AW'(`TDX_OFF_IDIS) || a == AW'(`TDX_OFF_KEY1A) ||
            a == AW'(`TDX_OFF_KEY1B) || a == AW'(`TDX_OFF_KEY2A) ||
            a == AW'(`TDX_OFF_KEY2B) || a == AW'(`TDX_OFF_KEY3A) ||
            a == AW'(`TDX_OFF_KEY3B) || a == AW'(`TDX_OFF_IN0) ||
            a == AW'(`TDX_OFF_IN1) || a == AW'(`TDX_OFF_IV0) ||
            a == AW'(`TDX_OFF_IV1);
  endfunction : is_wo

  function automatic logic hit(input logic [AW-1:0] a, input logic [11:0] off);
    hit = a == AW'(off);
  endfunction : hit

  // ****************************************
  // bus events
  // ****************************************
  logic wr_fire;
  logic rd_fire;
  logic is_dma;
  logic run;
  logic soft_rst;
  logic start_cmd;
  logic in_wr;
  logic in_wr_ok;
  logic out_rd;
  logic mode_wr;
  logic [31:0] status;
  logic [31:0] rd_data;
  logic        rd_err;

  assign wr_fire   = aw_full && w_full && !s_axi_bvalid;
  assign rd_fire   = s_axi_arvalid && s_axi_arready;
  assign is_dma    = mode_reg.start_method == `TDX_SM_DMA;
  assign run       = st_reg != TDX_IDLE;
  assign soft_rst  = wr_fire && hit(aw_addr, `TDX_OFF_CTRL) && w_data[`TDX_CTRL_SRST];
  assign start_cmd = wr_fire && hit(aw_addr, `TDX_OFF_CTRL) && w_data[`TDX_CTRL_START];
  assign in_wr     = wr_fire && (hit(aw_addr, `TDX_OFF_IN0) || hit(aw_addr, `TDX_OFF_IN1));
  assign in_wr_ok  = in_wr && !(is_dma && run);
  assign out_rd    = rd_fire && (hit(s_axi_araddr, `TDX_OFF_OUT0) || hit(s_axi_araddr, `TDX_OFF_OUT1));
  assign mode_wr   = wr_fire && hit(aw_addr, `TDX_OFF_MODE);

  always_comb begin
    status = 32'h0;
    status[`TDX_ST_READY]  = ready_reg;
    status[`TDX_ST_RDONE]  = rdone;
    status[`TDX_ST_TDONE]  = tdone;
    status[`TDX_ST_RFULL]  = rfull;
    status[`TDX_ST_TEMPTY] = tempty;
    status[`TDX_ST_BAD]    = bad_reg;
    status[`TDX_ST_KIND_HI:`TDX_ST_KIND_LO] = kind_reg;
  end

  // read decode; write-only words read as zero
  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    if (hit(s_axi_araddr, `TDX_OFF_MODE)) begin
      rd_data = mode_reg;
    // (RULE1) mask readback
    end else if (hit(s_axi_araddr, `TDX_OFF_IMASK)) begin
      rd_data = {23'h0, mask_reg};
    end else if (hit(s_axi_araddr, `TDX_OFF_ISTAT)) begin
      rd_data = status;
    // (RULE20) first word is upper half
    end else if (hit(s_axi_araddr, `TDX_OFF_OUT0)) begin
      rd_data = out_reg[63:32];
    end else if (hit(s_axi_araddr, `TDX_OFF_OUT1)) begin
      rd_data = out_reg[31:0];
    end else if (hit(s_axi_araddr, `TDX_OFF_RCNT)) begin
      rd_data = 32'(rcnt);
    end else if (hit(s_axi_araddr, `TDX_OFF_RNCNT)) begin
      rd_data = 32'(rnext);
    end else if (hit(s_axi_araddr, `TDX_OFF_TCNT)) begin
      rd_data = 32'(tcnt);
    end else if (hit(s_axi_araddr, `TDX_OFF_TNCNT)) begin
      rd_data = 32'(tnext);
    end else if (!is_wo(s_axi_araddr)) begin
      rd_err = 1'b1;
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TDX_RESP_OK;
    end else begin
      s_axi_awready <= !aw_full && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_full && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[1:0] != 2'h0 || aw_addr > AW'(`TDX_OFF_TNCNT)) ?
                        `TDX_RESP_ERR : `TDX_RESP_OK;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_full       <= 1'b0;
        w_full        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `TDX_RESP_OK;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_err ? `TDX_RESP_ERR : `TDX_RESP_OK;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // configuration and data words
  // ****************************************
  // byte strobes are ignored: every register takes whole words
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      mode_reg <= `TDX_MODE_RST;
      keys_reg <= '0;
      iv_reg   <= 64'h0;
      mask_reg <= 9'h0;
    end else if (wr_fire) begin
      // a mode change mid-run is refused, not half applied
      if (mode_wr && !run) mode_reg <= w_data;
      if (hit(aw_addr, `TDX_OFF_IEN)) mask_reg <= mask_reg | (w_data[8:0] & `TDX_IRQ_BITS);
      if (hit(aw_addr, `TDX_OFF_IDIS)) mask_reg <= mask_reg & ~w_data[8:0];
      // (RULE15) first key word is upper half
      if (hit(aw_addr, `TDX_OFF_KEY1A)) keys_reg.k1[63:32] <= w_data;
      if (hit(aw_addr, `TDX_OFF_KEY1B)) keys_reg.k1[31:0]  <= w_data;
      if (hit(aw_addr, `TDX_OFF_KEY2A)) keys_reg.k2[63:32] <= w_data;
      if (hit(aw_addr, `TDX_OFF_KEY2B)) keys_reg.k2[31:0]  <= w_data;
      if (hit(aw_addr, `TDX_OFF_KEY3A)) keys_reg.k3[63:32] <= w_data;
      if (hit(aw_addr, `TDX_OFF_KEY3B)) keys_reg.k3[31:0]  <= w_data;
      // (RULE21) chaining vector words
      if (hit(aw_addr, `TDX_OFF_IV0)) iv_reg[63:32] <= w_data;
      if (hit(aw_addr, `TDX_OFF_IV1)) iv_reg[31:0]  <= w_data;
    end
  end

  // (RULE19) input block, first word upper half
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      in_reg      <= 64'h0;
      in_seen_reg <= 2'h0;
    end else if (is_dma && dma_tx_valid && dma_tx_req) begin
      if (dma_idx_reg) in_reg[31:0] <= dma_tx_data;
      else in_reg[63:32] <= dma_tx_data;
    end else if (in_wr_ok) begin
      if (hit(aw_addr, `TDX_OFF_IN0)) begin
        in_reg[63:32]  <= w_data;
        in_seen_reg[0] <= 1'b1;
      end else begin
        in_reg[31:0]   <= w_data;
        in_seen_reg[1] <= 1'b1;
      end
    end else if (in_seen_reg == 2'h3 || start_cmd) begin
      in_seen_reg <= 2'h0;
    end
  end

  // ****************************************
  // sequencing
  // ****************************************
  logic core_start;
  assign core_start = !core_busy && st_reg == TDX_IDLE && (
    (mode_reg.start_method == `TDX_SM_MANUAL && start_cmd) ||
    (mode_reg.start_method == `TDX_SM_AUTO && in_seen_reg == 2'h3) ||
    (is_dma && dma_tx_valid && dma_tx_req && dma_idx_reg));

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      st_reg      <= TDX_IDLE;
      dma_idx_reg <= 1'b0;
      dma_tx_req  <= 1'b0;
      dma_rx_req  <= 1'b0;
      dma_rx_data <= 32'h0;
    end else begin
      case (st_reg)
        TDX_IDLE: begin
          // ask for words only while the transmit counter has some left
          dma_tx_req <= is_dma && tcnt != '0 && !dma_tx_valid;
          if (dma_tx_valid && dma_tx_req) dma_idx_reg <= !dma_idx_reg;
          if (core_start) st_reg <= TDX_BUSY;
        end
        TDX_BUSY: begin
          dma_tx_req  <= 1'b0;
          dma_idx_reg <= 1'b0;
          if (core_done) begin
            // (RULE23) receive side gets it with last_output_mode zero
            if (is_dma && !mode_reg.last_output_mode) begin
              st_reg      <= TDX_DRN0;
              dma_rx_req  <= 1'b1;
              dma_rx_data <= core_res[63:32];
            end else begin
              st_reg <= TDX_IDLE;
            end
          end
        end
        TDX_DRN0: begin
          if (dma_rx_ack) begin
            st_reg      <= TDX_DRN1;
            dma_rx_data <= out_reg[31:0];
          end
        end
        TDX_DRN1: begin
          if (dma_rx_ack) begin
            st_reg     <= TDX_IDLE;
            dma_rx_req <= 1'b0;
          end
        end
        default: st_reg <= TDX_IDLE;
      endcase
    end
  end

  // (RULE23) output words hold each result
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) out_reg <= 64'h0;
    else if (core_done) out_reg <= core_res;
  end

  // ****************************************
  // flags
  // ****************************************
  // (RULE2) done sets; set beats every clear except soft reset
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      // (RULE3) soft reset clears
      ready_reg <= 1'b0;
    end else if (core_done) begin
      ready_reg <= 1'b1;
    // (RULE3) start command clears
    end else if (start_cmd) begin
      ready_reg <= 1'b0;
    // (RULE6) dma drain ends the result
    end else if (st_reg == TDX_DRN1 && dma_rx_ack) begin
      ready_reg <= 1'b0;
    // (RULE6) dma input starts the next
    end else if (is_dma && mode_reg.last_output_mode && dma_tx_valid && dma_tx_req) begin
      ready_reg <= 1'b0;
    // (RULE4) output read clears
    end else if (!is_dma && !mode_reg.last_output_mode && out_rd) begin
      ready_reg <= 1'b0;
    // (RULE5) input write clears
    end else if (!is_dma && mode_reg.last_output_mode && in_wr) begin
      ready_reg <= 1'b0;
    end
  end

  // (RULE11) (RULE12) sticky until soft reset
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      // (RULE14) kind cleared only here
      bad_reg  <= 1'b0;
      kind_reg <= `TDX_BK_IN_DMA;
    end else begin
      // (RULE13) (RULE14) latest kind wins
      if (rd_fire && is_wo(s_axi_araddr)) begin
        bad_reg  <= 1'b1;
        kind_reg <= `TDX_BK_WO_RD;
      end else if (mode_wr && run) begin
        bad_reg  <= 1'b1;
        kind_reg <= `TDX_BK_MODE_WR;
      end else if (out_rd && run) begin
        bad_reg  <= 1'b1;
        kind_reg <= `TDX_BK_OUT_RD;
      end else if (in_wr && is_dma && run) begin
        bad_reg  <= 1'b1;
        kind_reg <= `TDX_BK_IN_DMA;
      end
    end
  end

  // (RULE25) masked status onto irq
  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= |(status[8:0] & mask_reg);
  end

  // ****************************************
  // engine and dma counters
  // ****************************************
  tdx_core #(.LAT(LAT)) u_core (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .soft_rst   (soft_rst),
    .start      (core_start),
    .mode       (mode_reg),
    .keys       (keys_reg),
    .block      (dma_idx_reg && is_dma ? {in_reg[63:32], dma_tx_data} : in_reg),
    .chain      (iv_reg),
    .busy_reg   (core_busy),
    .done_reg   (core_done),
    .result_reg (core_res)
  );

  // (RULE7) (RULE9) receive counters
  tdx_dma_count #(.W(CW)) u_rx (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .soft_rst      (soft_rst),
    .cnt_we        (wr_fire && hit(aw_addr, `TDX_OFF_RCNT)),
    .next_we       (wr_fire && hit(aw_addr, `TDX_OFF_RNCNT)),
    .wdata         (w_data[CW-1:0]),
    .step          (dma_rx_req && dma_rx_ack),
    .cnt_reg       (rcnt),
    .next_reg      (rnext),
    .reached_reg   (rdone),
    .both_zero_reg (rfull)
  );

  // (RULE8) (RULE10) transmit counters
  tdx_dma_count #(.W(CW)) u_tx (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .soft_rst      (soft_rst),
    .cnt_we        (wr_fire && hit(aw_addr, `TDX_OFF_TCNT)),
    .next_we       (wr_fire && hit(aw_addr, `TDX_OFF_TNCNT)),
    .wdata         (w_data[CW-1:0]),
    .step          (dma_tx_req && dma_tx_valid),
    .cnt_reg       (tcnt),
    .next_reg      (tnext),
    .reached_reg   (tdone),
    .both_zero_reg (tempty)
  );
endmodule : tdx_top
`default_nettype wire

// File: tdx_map.svh
`ifndef TDX_MAP_SVH
`define TDX_MAP_SVH
// ****************************************
// register byte offsets
// ****************************************
`define TDX_OFF_CTRL   12'h000
`define TDX_OFF_MODE   12'h004
`define TDX_OFF_IEN    12'h010
`define TDX_OFF_IDIS   12'h014
`define TDX_OFF_IMASK  12'h018
`define TDX_OFF_ISTAT  12'h01C
`define TDX_OFF_KEY1A  12'h020
`define TDX_OFF_KEY1B  12'h024
`define TDX_OFF_KEY2A  12'h028
`define TDX_OFF_KEY2B  12'h02C
`define TDX_OFF_KEY3A  12'h030
`define TDX_OFF_KEY3B  12'h034
`define TDX_OFF_IN0    12'h040
`define TDX_OFF_IN1    12'h044
`define TDX_OFF_OUT0   12'h050
`define TDX_OFF_OUT1   12'h054
`define TDX_OFF_IV0    12'h060
`define TDX_OFF_IV1    12'h064
`define TDX_OFF_RCNT   12'h104
`define TDX_OFF_TCNT   12'h10C
`define TDX_OFF_RNCNT  12'h114
`define TDX_OFF_TNCNT  12'h11C
// ****************************************
// field positions
// ****************************************
`define TDX_CTRL_START 0
`define TDX_CTRL_SRST  8
`define TDX_ST_READY   0
`define TDX_ST_RDONE   1
`define TDX_ST_TDONE   2
`define TDX_ST_RFULL   3
`define TDX_ST_TEMPTY  4
`define TDX_ST_BAD     8
`define TDX_ST_KIND_LO 12
`define TDX_ST_KIND_HI 13
`define TDX_IRQ_BITS   9'h11F
// ****************************************
// codes, reset values and timing
// ****************************************
`define TDX_SM_MANUAL  2'h0
`define TDX_SM_AUTO    2'h1
`define TDX_SM_DMA     2'h2
`define TDX_CH_ECB     2'h0
`define TDX_BK_IN_DMA  2'h0
`define TDX_BK_OUT_RD  2'h1
`define TDX_BK_MODE_WR 2'h2
`define TDX_BK_WO_RD   2'h3
`define TDX_MODE_RST   32'h0000_0000
`define TDX_RESP_OK    2'h0
`define TDX_RESP_ERR   2'h2
`define TDX_CORE_LAT   6'h10
`endif

// File: tdx_pkg.sv
package tdx_pkg;
  // mode register fields in bit order
  typedef struct packed {
    logic [15:0] rsv_hi;
    logic        last_output_mode;
    logic        rsv_14;
    logic [1:0]  chain_mode;
    logic [1:0]  rsv_11;
    logic [1:0]  start_method;
    logic [2:0]  rsv_7;
    logic        key_count_select;
    logic [1:0]  rsv_3;
    logic        triple_select;
    logic        cipher;
  } tdx_mode_t;

  typedef struct packed {
    logic [63:0] k1;
    logic [63:0] k2;
    logic [63:0] k3;
  } tdx_keys_t;

  typedef enum logic [1:0] {
    TDX_IDLE  = 2'b00,
    TDX_BUSY  = 2'b01,
    TDX_DRN0  = 2'b10,
    TDX_DRN1  = 2'b11
  } tdx_state_t;
endpackage : tdx_pkg

// File: tdx_dma_count.sv
`timescale 1ns/10ps
`default_nettype none
`include "tdx_map.svh"
module tdx_dma_count
  import tdx_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         soft_rst,
  // software writes
  input  wire logic         cnt_we,
  input  wire logic         next_we,
  input  wire logic [W-1:0] wdata,
  // one word moved
  input  wire logic         step,
  // state
  output logic      [W-1:0] cnt_reg,
  output logic      [W-1:0] next_reg,
  output logic              reached_reg,
  output logic              both_zero_reg
);
  // ****************************************
  // counters
  // ****************************************
  // reload from the next counter once the active one runs out
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      cnt_reg  <= '0;
      next_reg <= '0;
    end else if (cnt_we || next_we) begin
      if (cnt_we) cnt_reg <= wdata;
      if (next_we) next_reg <= wdata;
    end else if (cnt_reg == '0 && next_reg != '0) begin
      cnt_reg  <= next_reg;
      next_reg <= '0;
    end else if (step && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  // ****************************************
  // flags
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      reached_reg   <= 1'b0;
      both_zero_reg <= 1'b0;
    end else begin
      // (RULE7) zero since last write
      if (cnt_we || next_we) reached_reg <= 1'b0;
      else if (cnt_reg == '0) reached_reg <= 1'b1;
      // (RULE9) both counters zero
      both_zero_reg <= (cnt_reg == '0) && (next_reg == '0);
    end
  end
endmodule : tdx_dma_count
`default_nettype wire

// File: tdx_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "tdx_map.svh"
module tdx_core
  import tdx_pkg::*;
#(
  parameter int LAT = 16
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        soft_rst,
  // request
  input  wire logic        start,
  input  wire tdx_mode_t   mode,
  input  wire tdx_keys_t   keys,
  input  wire logic [63:0] block,
  input  wire logic [63:0] chain,
  // answer
  output logic             busy_reg,
  output logic             done_reg,
  output logic      [63:0] result_reg
);
  // stand-in mixing stage: the round network is kept outside this block,
  // only the key selection, the chaining vector selection and latency are modelled here
  logic [5:0]  left_reg;
  logic [63:0] kmix;
  logic [63:0] cv;

  always_comb begin
    kmix = keys.k1;
    // (RULE17) second key only in triple
    if (mode.triple_select) begin
      // (RULE18) (RULE24) two-key reuses first key
      kmix = keys.k1 ^ keys.k2 ^ (mode.key_count_select ? keys.k1 : keys.k3);
    end
    cv = (mode.chain_mode == `TDX_CH_ECB) ? 64'h0 : chain;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      busy_reg   <= 1'b0;
      done_reg   <= 1'b0;
      left_reg   <= '0;
      result_reg <= 64'h0;
    end else begin
      done_reg <= 1'b0;
      if (start && !busy_reg) begin
        busy_reg   <= 1'b1;
        left_reg   <= 6'(LAT);
        result_reg <= mode.cipher ? (block ^ cv) ^ kmix : (block ^ kmix) ^ cv;
      end else if (busy_reg) begin
        left_reg <= left_reg - 6'h1;
        if (left_reg == 6'h1) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end
endmodule : tdx_core
`default_nettype wire

// File: tdx_checker.sv
`timescale 1ns/10ps
`default_nettype none
module tdx_checker (
  // bus side
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // dma side
  input wire logic        dma_tx_req,
  input wire logic        dma_tx_valid
);
  // ****
  // handshakes
  // ****
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid lost");
  aw_block_a:
    assert property (s_axi_bvalid |-> !s_axi_awready) else $error("awready early");
  r_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata");
  ar_block_a:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
  r_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
  r_cause_a:
    assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid)) else $error("stray rvalid");
  r_done_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
  tx_drop_a:
    assert property (dma_tx_req && dma_tx_valid |=> !dma_tx_req) else $error("tx req stuck");
endmodule : tdx_checker
bind tdx_top tdx_checker tdx_checker_i (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .dma_tx_req, .dma_tx_valid);
`default_nettype wire

// File: tdx_dma_model.sv
`timescale 1ns/10ps
`default_nettype none
module tdx_dma_model (
  // clock
  input  wire logic        aclk,
  // words into the engine
  input  wire logic        dma_tx_req,
  output logic             dma_tx_valid = 1'b0,
  output logic      [31:0] dma_tx_data = 32'h5A5A_A5A5,
  // words out of the engine
  input  wire logic        dma_rx_req,
  output logic             dma_rx_ack = 1'b0
);
  // ****
  // paced channel
  // ****
  logic [1:0] t = 2'h0;
  // idle one cycle in four so slow answers are seen too
  always_ff @(posedge aclk) begin
    t            <= t + 2'h1;
    dma_tx_valid <= dma_tx_req && !dma_tx_valid && t != 2'h0;
    dma_rx_ack   <= dma_rx_req && !dma_rx_ack && t != 2'h0;
    dma_tx_data  <= ~dma_tx_data;
  end
endmodule : tdx_dma_model
`default_nettype wire

// File: test_tdx_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tdx_map.svh"
`define CHK(n,e,s) begin n_checks++; if ((s)!==(e)) begin bad_count++; $display("MISMATCH %s %h %h",n,e,s); end end
module test_tdx_top;
  logic        aclk=0, aresetn=0, s_axi_awvalid=0, s_axi_wvalid=0, s_axi_bready=0, s_axi_arvalid=0, s_axi_rready=0;
  logic [11:0] s_axi_awaddr=0, s_axi_araddr=0;
  logic [31:0] s_axi_wdata=0, seed=82, d, q, p, s_axi_rdata, dma_tx_data, dma_rx_data;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        dma_tx_req, dma_tx_valid, dma_rx_req, dma_rx_ack, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  int          bad_count=0, n_checks=0;
  always #4 aclk = ~aclk;
  tdx_top tdx_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dma_tx_req,
    .dma_tx_valid, .dma_tx_data, .dma_rx_req, .dma_rx_data, .dma_rx_ack, .irq);
  tdx_dma_model tdx_dma_model_i (.aclk, .dma_tx_req, .dma_tx_valid, .dma_tx_data, .dma_rx_req, .dma_rx_ack);
  // ****
  // bus tasks
  // ****
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
  // ****
  // scenarios
  // ****
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) begin
      q = rnd() & 32'h11F;
      p = rnd();
      wr(`TDX_OFF_IEN, q);
      wr(`TDX_OFF_IDIS, p);
      rd(`TDX_OFF_IMASK);
      `CHK("mask", q & ~p, d)
      wr(`TDX_OFF_IDIS, 32'h11F);
    end
    wr(`TDX_OFF_IN0, rnd()); // code book mode, vector left alone
    wr(`TDX_OFF_IN1, rnd());
    wr(`TDX_OFF_CTRL, 32'h1);
    d = 32'h0;
    for (int i = 0; i < 40 && !d[0]; i++) rd(`TDX_OFF_ISTAT);
    `CHK("ready", 1'b1, d[0])
    rd(`TDX_OFF_OUT0);
    rd(`TDX_OFF_ISTAT);
    `CHK("ready clr", 1'b0, d[0])
    wr(`TDX_OFF_IEN, 32'h100);
    wr(`TDX_OFF_CTRL, 32'h1);
    rd(`TDX_OFF_OUT0);
    wr(`TDX_OFF_MODE, 32'h1);
    rd(`TDX_OFF_ISTAT);
    `CHK("kind", 3'h6, {d[8], d[13:12]})
    `CHK("irq", 1'b1, irq)
    rd(`TDX_OFF_KEY1A);
    `CHK("key read", 32'h0, d)
    rd(`TDX_OFF_ISTAT);
    `CHK("kind", 3'h7, {d[8], d[13:12]})
    rd(12'h200);
    `CHK("resp", `TDX_RESP_ERR, rr)
    wr(`TDX_OFF_CTRL, 32'h100);
    `CHK("bresp", `TDX_RESP_OK, rr)
    rd(`TDX_OFF_ISTAT);
    `CHK("srst", 4'h0, {d[13:12], d[8], d[0]})
    wr(`TDX_OFF_RCNT, 32'h2);
    wr(`TDX_OFF_TCNT, 32'h2);
    wr(`TDX_OFF_MODE, 32'h201);
    d = 32'h0;
    for (int i = 0; i < 60 && !d[1]; i++) rd(`TDX_OFF_ISTAT);
    rd(`TDX_OFF_ISTAT);
    `CHK("dma flags", 5'h1E, d[4:0])
    test_done();
  end
endmodule : test_tdx_top
`default_nettype wire
